//--- src/delayed_por_timer.sv
// Delayed power-on reset timer with APB registers and pad/GPIO sources.
//
// Notes on behaviour
// - Reset pad is always a source.
// - Software may pick one GPIO source.
// - Delay multiplier is seven bits, max 7F.
// - Fire after multiplier times 4096 RC periods.
// - Delay multiplier resets to 18 hex.
// - Asserted source forces RC oscillator on.
// - Pad start uses default trim, pin programmed.
// - Selected pin still works as GPIO.
// - Pin number picks GPIO; zero disables.
// - Polarity 0 active low, 1 active high.
// - Count starts when any source asserts.
// - Early release clears count, no power-on reset.
// - Overlapping sources keep counting without clearing.
// - Every reset clears pin number field.
// - Power-on reset restores delay multiplier.
// - Short pad press gives hardware reset.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Overview.
// The block watches two reset sources and turns a long enough assertion of
// either one into a power-on reset for the rest of the chip.
// The reset pad is always a source and needs no set-up at all.
// One general-purpose pin may be added as a second source by software.
// The pin number field chooses that pin; the value zero switches it off, so
// pin zero can never serve as a source.
// The polarity bit chooses whether the pin counts as asserted when low or
// when high; the choice is applied before synchronisation, so the timer only
// ever sees an active-high request from each source.
// The pin is sampled and never driven, so it keeps its ordinary role.
//
// Both sources pass a two-flop synchroniser, which adds two clock cycles of
// latency to every start and every release.
// The delay counter advances on a tick that stands in for one period of the
// low-power RC clock. The tick comes from a divider of the main clock, and the
// divider only runs while the oscillator enable is high.
// A live source forces that enable high even when software has switched the
// oscillator off, so a held pad can always finish its count.
//
// The count is split into a twelve-bit sub-counter, which wraps every 4096
// ticks, and a multiplier counter, which steps on each wrap. The reset fires
// when the multiplier counter reaches the programmed delay multiplier.
// A delay of zero therefore fires as soon as the state machine has entered
// its counting state, a few cycles after the source asserts.
// Because the comparison is greater-or-equal, lowering the delay below the
// current count fires at once; software must expect that.
//
// A release of every source before expiry returns both counters to zero.
// Overlapping sources share one count: the second one may take over from
// the first without a restart, as long as one of them is always asserted.
// Once fired, the reset output stays high until every source has gone, and
// the counters are held at zero from its second cycle until it falls.
//
// A pad press that ends before expiry gives a one-cycle hardware reset pulse
// instead. A count opened by the pin gives no such pulse when cut short.
// The trim choice follows the source that opened the count: the reset
// default trim for the pad, the programmed trim for the pin.
//
// The power-on reset also restores the delay multiplier, and every reset
// kind clears the pin number and its polarity. A pin-based set-up must thus
// be written again after each reset, in the order pin, polarity, delay.
// One side effect is worth knowing: a pin-based reset clears its own pin
// selection, so its output lasts only the few cycles that the synchroniser
// needs to see the pin source vanish.
//
// The register bus answers with no wait states. Read data and the error flag
// are captured in the setup cycle and stand through the access cycle.

module delayed_por_timer #(
  parameter int unsigned RC_DIV = por_timer_pkg::RC_PERIOD_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        external_reset_pad,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Reset sources.
  input  wire logic        external_reset_pad_n,
  input  wire logic [31:0] gpioIn,
  input  wire logic        hwResetIn,
  input  wire logic        swResetIn,
  // Oscillator control.
  input  wire logic        rcOscSwEnable,
  output logic             rcOscEnable,
  output logic             rcTrimDefault,
  // Reset outputs.
  output logic             power_on_reset_out,
  output logic             hwResetOut
);

  // ==========================================================================
  // Declarations.
  logic [por_timer_pkg::DELAY_WIDTH-1:0]   delayMult;
  por_timer_pkg::pin_cfg_s                 pinCfg;
  logic                                    padMeta;
  logic                                    padSync;
  logic                                    pinMeta;
  logic                                    pinSync;
  logic                                    pinRaw;
  logic                                    anyActive;
  logic [por_timer_pkg::RC_DIV_WIDTH-1:0]  rcDivCount;
  logic                                    rcTick;
  logic [por_timer_pkg::SUB_WIDTH-1:0]     subCount;
  logic [por_timer_pkg::DELAY_WIDTH-1:0]   multCount;
  logic                                    padStarted;
  logic                                    expired;
  por_timer_pkg::timer_state_e             state;
  por_timer_pkg::timer_state_e             next_state;
  logic                                    setupPhase;
  logic                                    accessPhase;
  logic                                    wrDelay;
  logic                                    wrPin;
  logic [31:0]                             next_prdata;
  logic                                    next_slverr;

  // Returns high when the address names a mapped register.
  function automatic logic addrMapped(input logic [7:0] addr);
    addrMapped = (addr == por_timer_pkg::DELAY_CFG_OFFSET) ||
                 (addr == por_timer_pkg::PIN_CFG_OFFSET) ||
                 (addr == por_timer_pkg::STATUS_OFFSET);
  endfunction : addrMapped

  // ==========================================================================
  // APB decode: the slave answers in the first access cycle.
  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign pready      = accessPhase;
  assign wrDelay     = accessPhase && pwrite && (paddr == por_timer_pkg::DELAY_CFG_OFFSET);
  assign wrPin       = accessPhase && pwrite && (paddr == por_timer_pkg::PIN_CFG_OFFSET);

  // Read data and error are prepared from the setup cycle address.
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = !addrMapped(paddr);
    unique case (paddr)
      por_timer_pkg::DELAY_CFG_OFFSET: begin
        next_prdata[por_timer_pkg::DELAY_LSB +: por_timer_pkg::DELAY_WIDTH] = delayMult;
      end
      por_timer_pkg::PIN_CFG_OFFSET: begin
        next_prdata[por_timer_pkg::PIN_SEL_LSB +: por_timer_pkg::PIN_SEL_WIDTH] = pinCfg.select;
        next_prdata[por_timer_pkg::PIN_POL_BIT] = pinCfg.polarity;
      end
      por_timer_pkg::STATUS_OFFSET: begin
        next_prdata[por_timer_pkg::ST_COUNT_LSB +: por_timer_pkg::SUB_WIDTH] = subCount;
        next_prdata[por_timer_pkg::ST_MULT_LSB +: por_timer_pkg::DELAY_WIDTH] = multCount;
        next_prdata[por_timer_pkg::ST_ACTIVE_BIT] = anyActive;
        next_prdata[por_timer_pkg::ST_FIRED_BIT]  = power_on_reset_out;
        next_prdata[por_timer_pkg::ST_PAD_BIT]    = padSync;
        next_prdata[por_timer_pkg::ST_PIN_BIT]    = pinSync;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data and error flag are registered in the setup cycle.
  always_ff @(posedge mclk or negedge external_reset_pad) begin
    if (!external_reset_pad) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_slverr;
    end
  end

  // ==========================================================================
  // Delay register: seven bits, restored only by power-on reset and external_reset_pad.
  always_ff @(posedge mclk or negedge external_reset_pad) begin
    if (!external_reset_pad) begin
      delayMult <= por_timer_pkg::DELAY_RESET;
    end else if (power_on_reset_out) begin
      delayMult <= por_timer_pkg::DELAY_RESET;
    end else if (wrDelay) begin
      delayMult <= pwdata[por_timer_pkg::DELAY_LSB +: por_timer_pkg::DELAY_WIDTH];
    end
  end

  // Pin source register: the pin number does not survive any reset.
  always_ff @(posedge mclk or negedge external_reset_pad) begin
    if (!external_reset_pad) begin
      pinCfg.select   <= por_timer_pkg::PIN_SEL_RESET;
      pinCfg.polarity <= por_timer_pkg::PIN_POL_RESET;
    end else if (power_on_reset_out || hwResetOut || hwResetIn || swResetIn) begin
      pinCfg.select   <= por_timer_pkg::PIN_SEL_RESET;
      pinCfg.polarity <= por_timer_pkg::PIN_POL_RESET;
    end else if (wrPin) begin
      pinCfg.select   <= pwdata[por_timer_pkg::PIN_SEL_LSB +: por_timer_pkg::PIN_SEL_WIDTH];
      pinCfg.polarity <= pwdata[por_timer_pkg::PIN_POL_BIT];
    end
  end

  // ==========================================================================
  // Source conditioning. The pin is only sampled, never driven, so it keeps
  // its normal GPIO role elsewhere in the chip.
  always_comb begin
    pinRaw = 1'b0;
    if (pinCfg.select != por_timer_pkg::PIN_SEL_RESET) begin
      pinRaw = gpioIn[pinCfg.select] ~^ pinCfg.polarity;
    end
  end

  // Two-flop synchronisers; polarity is applied before the first stage.
  always_ff @(posedge mclk or negedge external_reset_pad) begin
    if (!external_reset_pad) begin
      padMeta <= 1'b0;
      padSync <= 1'b0;
      pinMeta <= 1'b0;
      pinSync <= 1'b0;
    end else begin
      padMeta <= !external_reset_pad_n;
      padSync <= padMeta;
      pinMeta <= pinRaw;
      pinSync <= pinMeta;
    end
  end

  assign anyActive = padSync || pinSync;

  // ==========================================================================
  // Oscillator control: a live source overrides a software switch-off.
  assign rcOscEnable   = rcOscSwEnable || anyActive;

  // Trim choice. While idle the pad decides directly, so a count opened by the
  // pin never shows a stale pad flag from an earlier count in its first cycle.
  always_comb begin
    rcTrimDefault = 1'b0;
    if (anyActive) begin
      if (state == por_timer_pkg::ST_IDLE) begin
        rcTrimDefault = padSync;
      end else begin
        rcTrimDefault = padStarted;
      end
    end
  end

  // RC period divider; it only ticks while the oscillator runs.
  always_ff @(posedge mclk or negedge external_reset_pad) begin
    if (!external_reset_pad) begin
      rcDivCount <= '0;
      rcTick     <= 1'b0;
    end else if (!rcOscEnable) begin
      rcDivCount <= '0;
      rcTick     <= 1'b0;
    end else if (rcDivCount >= por_timer_pkg::RC_DIV_WIDTH'(RC_DIV - 1)) begin
      rcDivCount <= '0;
      rcTick     <= 1'b1;
    end else begin
      rcDivCount <= rcDivCount + 1'b1;
      rcTick     <= 1'b0;
    end
  end

  // ==========================================================================
  // Timer state machine.
  assign expired = (multCount >= delayMult);

  always_comb begin
    next_state = state;
    unique case (state)
      por_timer_pkg::ST_IDLE: begin
        if (anyActive) begin
          next_state = por_timer_pkg::ST_COUNT;
        end
      end
      por_timer_pkg::ST_COUNT: begin
        if (!anyActive) begin
          next_state = por_timer_pkg::ST_IDLE;
        end else if (expired) begin
          next_state = por_timer_pkg::ST_FIRED;
        end
      end
      por_timer_pkg::ST_FIRED: begin
        if (!anyActive) begin
          next_state = por_timer_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = por_timer_pkg::ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge mclk or negedge external_reset_pad) begin
    if (!external_reset_pad) begin
      state <= por_timer_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counter: 4096 RC periods per multiplier step. It keeps running while any
  // source holds, so overlapping sources add up without a restart.
  always_ff @(posedge mclk or negedge external_reset_pad) begin
    if (!external_reset_pad) begin
      subCount  <= '0;
      multCount <= '0;
    end else if (state != por_timer_pkg::ST_COUNT || !anyActive) begin
      subCount  <= '0;
      multCount <= '0;
    end else if (rcTick && !expired) begin
      subCount <= subCount + 1'b1;
      if (subCount == por_timer_pkg::SUB_LAST) begin
        multCount <= multCount + 1'b1;
      end
    end
  end

  // Records which source opened the count, for the trim choice.
  always_ff @(posedge mclk or negedge external_reset_pad) begin
    if (!external_reset_pad) begin
      padStarted <= 1'b0;
    end else if (state == por_timer_pkg::ST_IDLE && anyActive) begin
      padStarted <= padSync;
    end
  end

  // ==========================================================================
  // Reset outputs. The power-on reset holds until all sources release; a pad
  // press that ends early yields a one-cycle hardware reset pulse instead.
  always_ff @(posedge mclk or negedge external_reset_pad) begin
    if (!external_reset_pad) begin
      power_on_reset_out <= 1'b0;
      hwResetOut         <= 1'b0;
    end else begin
      power_on_reset_out <= (next_state == por_timer_pkg::ST_FIRED);
      hwResetOut <= (state == por_timer_pkg::ST_COUNT) && !anyActive && padStarted;
    end
  end

endmodule : delayed_por_timer

`default_nettype wire

//--- src/por_timer_pkg.sv
// Constants, register layout and types for the delayed power-on reset timer.
package por_timer_pkg;

  // ==========================================================================
  // Register map (byte addresses on the APB).
  localparam logic [7:0] DELAY_CFG_OFFSET  = 8'h00;
  localparam logic [7:0] PIN_CFG_OFFSET    = 8'h04;
  localparam logic [7:0] STATUS_OFFSET     = 8'h08;

  // ==========================================================================
  // Field layout.
  localparam int unsigned DELAY_LSB        = 0;
  localparam int unsigned DELAY_WIDTH      = 7;
  localparam int unsigned PIN_SEL_LSB      = 0;
  localparam int unsigned PIN_SEL_WIDTH    = 5;
  localparam int unsigned PIN_POL_BIT      = 8;
  localparam int unsigned ST_COUNT_LSB     = 0;
  localparam int unsigned ST_MULT_LSB      = 12;
  localparam int unsigned ST_ACTIVE_BIT    = 24;
  localparam int unsigned ST_FIRED_BIT     = 25;
  localparam int unsigned ST_PAD_BIT       = 26;
  localparam int unsigned ST_PIN_BIT       = 27;
  localparam int unsigned GPIO_COUNT       = 32;

  // ==========================================================================
  // Reset values.
  localparam logic [DELAY_WIDTH-1:0]   DELAY_RESET   = 7'h18;
  localparam logic [PIN_SEL_WIDTH-1:0] PIN_SEL_RESET = 5'h00;
  localparam logic                     PIN_POL_RESET = 1'b0;

  // ==========================================================================
  // Timing.
  localparam int unsigned MCLK_PERIOD_PS   = 20000;
  localparam int unsigned RC_PERIOD_PS     = 31250000;
  localparam int unsigned RC_PERIOD_CYCLES = RC_PERIOD_PS / MCLK_PERIOD_PS;
  localparam int unsigned RC_DIV_WIDTH     = 16;
  localparam int unsigned SUB_WIDTH        = 12;
  localparam logic [SUB_WIDTH-1:0] SUB_LAST = 12'hFFF;

  // ==========================================================================
  // Types.
  typedef struct packed {
    logic                     polarity;
    logic [PIN_SEL_WIDTH-1:0] select;
  } pin_cfg_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_COUNT = 3'b010,
    ST_FIRED = 3'b100
  } timer_state_e;

endpackage : por_timer_pkg

//--- verif/delayed_por_timer_monitor.sv
// Port-level assertions for the delayed power-on reset timer.
`timescale 1ns/1ps
`default_nettype none

module delayed_por_timer_monitor #(
  parameter int unsigned RC_DIV = 2
) (
  input wire logic        mclk,
  input wire logic        external_reset_pad,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        external_reset_pad_n,
  input wire logic [31:0] gpioIn,
  input wire logic        hwResetIn,
  input wire logic        swResetIn,
  input wire logic        rcOscSwEnable,
  input wire logic        rcOscEnable,
  input wire logic        rcTrimDefault,
  input wire logic        power_on_reset_out,
  input wire logic        hwResetOut
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!external_reset_pad);

  // ==========================================================================
  // Steps: pad held long enough to pass the synchroniser, pulse ending.
  sequence s_padHeld;
    !external_reset_pad_n [*6];
  endsequence
  sequence s_hwEnds;
    !hwResetOut;
  endsequence
  property p_padWakesOsc; s_padHeld |-> rcOscEnable; endproperty
  property p_swOsc; rcOscSwEnable |-> rcOscEnable; endproperty
  property p_trimRunning; rcTrimDefault |-> rcOscEnable; endproperty
  property p_trimFromPad; $rose(rcTrimDefault) |-> !$past(external_reset_pad_n, 2); endproperty
  property p_porHeld; s_padHeld ##0 power_on_reset_out |=> power_on_reset_out; endproperty
  property p_porDrops; $fell(power_on_reset_out) |-> $past(external_reset_pad_n, 2); endproperty
  property p_hwPulse; hwResetOut |-> !power_on_reset_out ##1 s_hwEnds; endproperty
  property p_hwCause; $rose(hwResetOut) |-> $past(external_reset_pad_n, 2); endproperty

  // ==========================================================================
  // Checks.
  a_padWakesOsc: assert property (p_padWakesOsc) else $error("Oscillator off while pad held.");
  a_swOsc: assert property (p_swOsc) else $error("Software enable ignored.");
  a_trimRunning: assert property (p_trimRunning) else $error("Trim select without oscillator.");
  a_trimFromPad: assert property (p_trimFromPad) else $error("Default trim without pad.");
  a_porHeld: assert property (p_porHeld) else $error("Reset output dropped while pad held.");
  a_porDrops: assert property (p_porDrops) else $error("Reset output dropped early.");
  a_hwPulse: assert property (p_hwPulse) else $error("Hardware reset pulse malformed.");
  a_hwCause: assert property (p_hwCause) else $error("Hardware reset without release.");
endmodule : delayed_por_timer_monitor

bind delayed_por_timer delayed_por_timer_monitor #(.RC_DIV(RC_DIV)) monitor (
  .mclk(mclk), .external_reset_pad(external_reset_pad), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .external_reset_pad_n(external_reset_pad_n), .gpioIn(gpioIn), .hwResetIn(hwResetIn),
  .swResetIn(swResetIn), .rcOscSwEnable(rcOscSwEnable), .rcOscEnable(rcOscEnable),
  .rcTrimDefault(rcTrimDefault), .power_on_reset_out(power_on_reset_out), .hwResetOut(hwResetOut)
);
`default_nettype wire

//--- verif/reset_source_model.sv
// Reset button on the pad and a signal driver on one general-purpose pin.
`timescale 1ns/1ps
`default_nettype none

module reset_source_model (
  input  wire logic        mclk,
  input  wire logic        pressPad,
  input  wire logic        pinOn,
  input  wire logic        pinPol,
  input  wire logic [4:0]  pinIdx,
  output var  logic        padN,
  output var  logic [31:0] gpio
);
  logic [31:0] noise = 32'h0;

  // The pad has a pull-up, so it reads high from the clock edge after the button is let go.
  initial padN = 1'b1;
  always @(posedge mclk) begin
    padN <= ~pressPad;
    noise <= ~noise;
  end

  // Other pins toggle every cycle, so a wrong pin choice cannot look quiet.
  always_comb begin
    gpio = noise;
    gpio[pinIdx] = pinOn ? pinPol : ~pinPol;
  end
endmodule : reset_source_model
`default_nettype wire

//--- verif/delayed_por_timer_test.sv
// Self-checking bench for the delayed power-on reset timer.
`timescale 1ns/1ps
`default_nettype none

module delayed_por_timer_test;
  localparam int unsigned RC_DIV = 2;
  localparam int          FIRE   = 4096 * RC_DIV;
  localparam logic [7:0]  DLY    = por_timer_pkg::DELAY_CFG_OFFSET;
  localparam logic [7:0]  PIN    = por_timer_pkg::PIN_CFG_OFFSET;
  localparam logic [7:0]  STAT   = por_timer_pkg::STATUS_OFFSET;
  logic        mclk = 1'b0;
  logic        external_reset_pad, psel, penable, pwrite, pready, pslverr, hwResetIn, swResetIn, err;
  logic        rcOscSwEnable, rcOscEnable, rcTrimDefault, por, hwResetOut, padN;
  logic        pressPad, pinOn, pinPol;
  logic        hwSeen = 1'b0;
  logic        porSeen = 1'b0;
  logic [4:0]  pinIdx;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, gpio, rd;
  int          fail_count = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          t0 = 0;

  delayed_por_timer #(.RC_DIV(RC_DIV)) dut (
    .mclk(mclk), .external_reset_pad(external_reset_pad), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .external_reset_pad_n(padN),
    .gpioIn(gpio), .hwResetIn(hwResetIn), .swResetIn(swResetIn), .rcOscSwEnable(rcOscSwEnable),
    .rcOscEnable(rcOscEnable), .rcTrimDefault(rcTrimDefault), .power_on_reset_out(por), .hwResetOut(hwResetOut)
  );
  reset_source_model partner (
    .mclk(mclk), .pressPad(pressPad), .pinOn(pinOn), .pinPol(pinPol), .pinIdx(pinIdx), .padN(padN), .gpio(gpio)
  );

  // ==========================================================================
  // Clock, cycle count and sticky flags for the reset outputs.
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (hwResetOut === 1'b1) hwSeen <= 1'b1;
    if (por === 1'b1) porSeen <= 1'b1;
  end

  // ==========================================================================
  // Helpers.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One APB transfer; read data and error are taken at the completing edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic waitPor;
    while (por !== 1'b1 && cyc - t0 < 2 * FIRE) @(posedge mclk);
  endtask : waitPor

  function automatic logic inWin(input int lo, input int hi);
    return (cyc - t0 >= lo) && (cyc - t0 <= hi);
  endfunction : inWin

  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================================================
  // Tests.
  initial begin
    {external_reset_pad, psel, penable, pwrite, hwResetIn, swResetIn, rcOscSwEnable, pressPad, pinOn, pinPol} = '0;
    {pinIdx, paddr, pwdata} = '0;
    repeat (3) @(posedge mclk);
    external_reset_pad <= 1'b1;
    @(posedge mclk);
    apb(1'b0, DLY, 32'h0);
    check("delayReset", rd, 32'h18);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    apb(1'b1, DLY, 32'hFF);
    apb(1'b0, DLY, 32'h0);
    check("delayWidth", rd, 32'h7F);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, PIN, 32'h11F);
      apb(1'b0, PIN, 32'h0);
      check("pinCfg", rd, 32'h11F);
      {hwResetIn, swResetIn} <= 2'(i + 1);
      @(posedge mclk);
      {hwResetIn, swResetIn} <= 2'b00;
      apb(1'b0, PIN, 32'h0);
      check("pinClear", rd[4:0], 5'h0);
    end
    rcOscSwEnable <= 1'b1;
    repeat (2) @(posedge mclk);
    check("oscSw", rcOscEnable, 1'b1);
    rcOscSwEnable <= 1'b0;
    apb(1'b1, DLY, 32'h1);
    pressPad <= 1'b1;
    repeat (200) @(posedge mclk);
    check("padOsc", {rcOscEnable, rcTrimDefault}, 2'b11);
    pressPad <= 1'b0;
    repeat (10) @(posedge mclk);
    check("shortPress", {porSeen, hwSeen}, 2'b01);
    apb(1'b0, STAT, 32'h0);
    check("countCleared", rd[25:0], 26'h0);
    apb(1'b1, DLY, 32'h1);
    pressPad <= 1'b1;
    t0 = cyc;
    waitPor;
    check("padFire", inWin(FIRE - 2, FIRE + 20), 1'b1);
    apb(1'b0, DLY, 32'h0);
    check("delayAfterPor", rd, 32'h18);
    check("porHeld", por, 1'b1);
    pressPad <= 1'b0;
    repeat (10) @(posedge mclk);
    check("porReleased", por, 1'b0);
    apb(1'b1, PIN, 32'h5);
    apb(1'b1, PIN, 32'h105);
    apb(1'b1, DLY, 32'h1);
    {pinIdx, pinPol, pinOn} <= {5'd5, 2'b11};
    t0 = cyc;
    repeat (10) @(posedge mclk);
    check("pinOsc", {rcOscEnable, rcTrimDefault}, 2'b10);
    waitPor;
    check("pinFire", inWin(FIRE - 2, FIRE + 20), 1'b1);
    apb(1'b0, PIN, 32'h0);
    check("pinAfterPor", rd[4:0], 5'h0);
    pinOn <= 1'b0;
    repeat (10) @(posedge mclk);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, PIN, 32'(3 * (1 - i)));
      apb(1'b1, DLY, 32'h0);
      {porSeen, pinIdx, pinPol, pinOn} <= {1'b0, 5'(3 * (1 - i)), 2'b01};
      repeat (20) @(posedge mclk);
      check("activeLowPin", porSeen, 32'(1 - i));
      pinOn <= 1'b0;
      repeat (10) @(posedge mclk);
    end
    apb(1'b1, PIN, 32'h105);
    apb(1'b1, DLY, 32'h1);
    {hwSeen, pinIdx, pinPol, pressPad} <= {1'b0, 5'd5, 2'b11};
    t0 = cyc;
    repeat (FIRE / 2) @(posedge mclk);
    pinOn <= 1'b1;
    repeat (FIRE / 4) @(posedge mclk);
    pressPad <= 1'b0;
    waitPor;
    check("overlapFire", {inWin(FIRE - 2, FIRE + 20), hwSeen}, 2'b10);
    pinOn <= 1'b0;
    repeat (10) @(posedge mclk);
    finish_test;
  end

  // Watchdog well beyond the three full delays that the tests wait for.
  initial begin
    repeat (8 * FIRE) @(posedge mclk);
    fail_count++;
    finish_test;
  end
endmodule : delayed_por_timer_test
`default_nettype wire
